// ===== include/dwc_params.svh
// constants of the dual wiper command controller
// assumes a 100 MHz system clock; included by the controller only
`ifndef DWC_PARAMS_SVH
`define DWC_PARAMS_SVH
`define DWC_FRAME_BITS       24
`define DWC_FRAME_LAST       5'h17
`define DWC_WIPER_MID        10'h200
`define DWC_WIPER_MAX        10'h3ff
`define DWC_WIPER_MIN        10'h000
`define DWC_ADDR_FACTORY     4'hf
`define DWC_ADDR_USER_FIRST  4'h2
`define DWC_NV_WORDS         16
// reserved factory word; the value is arbitrary
`define DWC_FACTORY_WORD     16'h0000
`define DWC_CLK_PERIOD_NS    10
`define DWC_STORE_TIME_MS    25
`define DWC_STORE_CYCLES     ((`DWC_STORE_TIME_MS * 1000000) / `DWC_CLK_PERIOD_NS)
`define DWC_RDY_PULSE        4'h4
`endif

// ===== include/dwc_pkg.sv
// types of the dual wiper command controller
// assumes nothing beyond a SystemVerilog compiler
package dwc_pkg;
  typedef enum logic [3:0] {
    CMD_NOP        = 4'h0,
    CMD_RESTORE    = 4'h1,
    CMD_STORE_WIP  = 4'h2,
    CMD_STORE_DATA = 4'h3,
    CMD_DEC6       = 4'h4,
    CMD_DEC6_ALL   = 4'h5,
    CMD_DEC1       = 4'h6,
    CMD_DEC1_ALL   = 4'h7,
    CMD_RELOAD_ALL = 4'h8,
    CMD_READ_NV    = 4'h9,
    CMD_READ_WIP   = 4'ha,
    CMD_WRITE_WIP  = 4'hb,
    CMD_INC6       = 4'hc,
    CMD_INC6_ALL   = 4'hd,
    CMD_INC1       = 4'he,
    CMD_INC1_ALL   = 4'hf
  } dwc_cmd_t;

  typedef struct packed {
    dwc_cmd_t    cmd;
    logic [3:0]  addr;
    logic [15:0] data;
  } dwc_frame_t;

  typedef enum logic [1:0] {
    ST_BOOT  = 2'b00,
    ST_IDLE  = 2'b01,
    ST_STORE = 2'b11
  } dwc_state_t;
endpackage : dwc_pkg

// ===== rtl/dwc_dual_wiper_ctrl.sv
// command and control logic of a dual wiper controller with a serial link
// assumes sclk toggles only while cs_n is low and cs_n stays high a few clk
// cycles between frames; open-drain pins are resolved outside
//
// Summary of operation
// - frame is command, address, data; 24 bits
// - nonvolatile store takes about 25 ms
// - frames ignored while a store runs
// - ready held low through a store and briefly after
// - thirteen user words beside two wiper words
// - codes 0-3: nop, restore, store, store word
// - codes 4-7 decrement by 6 dB or step
// - codes 12-15 increment by 6 dB or step
// - codes 9 and 10 read back on output
// - code 11 writes data into wiper
// - zero is B end, 0x200 half scale
// - wiper registers rewrite freely, store limited
// - power-on loads wipers from stored values
// - stored wipers default to midscale
// - restore one channel, reset reloads both
// - strobe falling forces both wipers midscale
// - strobe rising reloads both stored values
// - write protect blocks all but reloads and reads
// - serial output off while chip select high
// - output echoes previous frame word
// - address bit zero selects the channel
// - input sampled on rising edge, MSB first
// - command runs when chip select rises
// - counter restarts; frames not a multiple of 24 bits dropped
`timescale 1ns/1ps
`include "dwc_params.svh"
module dwc_dual_wiper_ctrl #(
  parameter int unsigned STORE_CYCLES = `DWC_STORE_CYCLES
) (
  // system
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       ce,
  // serial link
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic       sdi,
  output logic            sdo_o,
  output logic            sdo_oe,
  // control pins
  input  wire logic       wp_n,
  input  wire logic       hardware_reload_strobe_n,
  output logic            rdy_o,
  output logic            rdy_oe,
  // wiper settings
  output logic [9:0]      wiper_setting_channel_one,
  output logic [9:0]      wiper_setting_channel_two
);

  localparam logic [21:0] STORE_LAST = 22'(STORE_CYCLES - 1);

  // link domain
  logic        frm_rst_b;
  logic        open_q;
  logic [23:0] rx_sh_q;
  logic [4:0]  bit_cnt_q;
  logic        frame_tgl_q;
  logic [23:0] tx_sh_q;
  logic        sdo_bit;
  // system domain
  logic [23:0] reply_q;
  logic        cs_s1_q;
  logic        cs_s2_q;
  logic        cs_s3_q;
  logic        tgl_s1_q;
  logic        tgl_s2_q;
  logic        tgl_seen_q;
  logic        wp_s1_q;
  logic        wp_s2_q;
  logic        rld_s1_q;
  logic        rld_s2_q;
  logic        rld_s3_q;
  logic        rld_armed_q;
  logic        have_prev_q;
  logic [21:0] store_cnt_q;
  logic [3:0]  rdy_cnt_q;
  logic [9:0]  wiper_setting_register [2];
  logic [15:0] nonvolatile_store [`DWC_NV_WORDS];
  dwc_pkg::dwc_state_t st_q;
  dwc_pkg::dwc_frame_t last_q;
  dwc_pkg::dwc_frame_t rx_frm;
  dwc_pkg::dwc_frame_t cur;
  logic        cs_rise;
  logic        new_bits;
  logic        frame_ok;
  logic        exec_go;
  logic        wp_ok;
  logic        rld_fall;
  logic        rld_rise;
  logic        store_go;
  logic        store_done;

  function automatic logic [9:0] dwc_adjust(input logic [9:0] w,
                                            input dwc_pkg::dwc_cmd_t c);
    logic [9:0] r;
    r = w;
    case (c)
      dwc_pkg::CMD_DEC6, dwc_pkg::CMD_DEC6_ALL: begin
        r = {1'b0, w[9:1]};
      end
      dwc_pkg::CMD_DEC1, dwc_pkg::CMD_DEC1_ALL: begin
        r = (w == `DWC_WIPER_MIN) ? w : w - 10'h1;
      end
      dwc_pkg::CMD_INC6, dwc_pkg::CMD_INC6_ALL: begin
        r = w[9] ? `DWC_WIPER_MAX : {w[8:0], 1'b0};
      end
      dwc_pkg::CMD_INC1, dwc_pkg::CMD_INC1_ALL: begin
        r = (w == `DWC_WIPER_MAX) ? w : w + 10'h1;
      end
      default: begin
        r = w;
      end
    endcase
    return r;
  endfunction : dwc_adjust

  // adjust codes have bit 2 set; the all-channel forms also bit 0
  function automatic logic dwc_hits(input dwc_pkg::dwc_frame_t f,
                                    input logic ch);
    logic adj;
    adj = f.cmd[2];
    return adj && (f.cmd[0] || (f.addr[0] == ch));
  endfunction : dwc_hits

  // ---------------- link domain ----------------
  assign frm_rst_b = rst_b & ~cs_n;

  // open_q marks that the current frame has seen its first bit
  always_ff @(posedge sclk or negedge frm_rst_b) begin
    if (!frm_rst_b) begin
      open_q <= 1'b0;
    end else begin
      open_q <= 1'b1;
    end
  end

  always_ff @(posedge sclk or negedge rst_b) begin
    if (!rst_b) begin
      rx_sh_q <= 24'h0;
    end else if (!cs_n) begin
      rx_sh_q <= {rx_sh_q[22:0], sdi};
    end
  end

  always_ff @(posedge sclk or negedge rst_b) begin
    if (!rst_b) begin
      bit_cnt_q   <= 5'h0;
      frame_tgl_q <= 1'b0;
    end else if (!cs_n) begin
      if (!open_q) begin
        bit_cnt_q   <= 5'h1;
        frame_tgl_q <= ~frame_tgl_q;
      end else begin
        bit_cnt_q <= (bit_cnt_q == `DWC_FRAME_LAST) ? 5'h0 : bit_cnt_q + 5'h1;
      end
    end
  end

  // reply word is stable while cs_n is low
  always_ff @(posedge sclk or negedge rst_b) begin
    if (!rst_b) begin
      tx_sh_q <= 24'h0;
    end else if (!cs_n) begin
      if (!open_q) begin
        tx_sh_q <= {reply_q[22:0], 1'b0};
      end else begin
        tx_sh_q <= {tx_sh_q[22:0], 1'b0};
      end
    end
  end

  assign sdo_bit = open_q ? tx_sh_q[23] : reply_q[23];
  assign sdo_o   = 1'b0;
  // released while chip select is high
  assign sdo_oe  = ~cs_n & ~sdo_bit;

  // ---------------- system domain ----------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cs_s1_q  <= 1'b1;
      cs_s2_q  <= 1'b1;
      cs_s3_q  <= 1'b1;
      tgl_s1_q <= 1'b0;
      tgl_s2_q <= 1'b0;
      wp_s1_q  <= 1'b1;
      wp_s2_q  <= 1'b1;
      rld_s1_q <= 1'b1;
      rld_s2_q <= 1'b1;
      rld_s3_q <= 1'b1;
    end else if (ce) begin
      cs_s1_q  <= cs_n;
      cs_s2_q  <= cs_s1_q;
      cs_s3_q  <= cs_s2_q;
      tgl_s1_q <= frame_tgl_q;
      tgl_s2_q <= tgl_s1_q;
      wp_s1_q  <= wp_n;
      wp_s2_q  <= wp_s1_q;
      rld_s1_q <= hardware_reload_strobe_n;
      rld_s2_q <= rld_s1_q;
      rld_s3_q <= rld_s2_q;
    end
  end

  assign rx_frm   = dwc_pkg::dwc_frame_t'(rx_sh_q);
  // act when chip select returns high
  assign cs_rise  = ce & cs_s2_q & ~cs_s3_q;
  assign new_bits = tgl_s2_q != tgl_seen_q;
  assign frame_ok = new_bits && (bit_cnt_q == 5'h0);
  assign cur      = new_bits ? rx_frm : last_q;
  // nothing is taken while a store runs
  assign exec_go  = cs_rise && (st_q == dwc_pkg::ST_IDLE) &&
                    (frame_ok || (!new_bits && have_prev_q));
  assign wp_ok    = wp_s2_q;
  assign rld_fall = ce & ~rld_s2_q & rld_s3_q;
  assign rld_rise = ce & rld_s2_q & ~rld_s3_q;
  assign store_go = exec_go && wp_ok &&
                    ((cur.cmd == dwc_pkg::CMD_STORE_WIP) ||
                     ((cur.cmd == dwc_pkg::CMD_STORE_DATA) &&
                      (cur.addr != `DWC_ADDR_FACTORY)));
  assign store_done = ce && (st_q == dwc_pkg::ST_STORE) &&
                      (store_cnt_q == STORE_LAST);

  // frame bookkeeping; a bare chip-select pulse repeats the last frame
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tgl_seen_q  <= 1'b0;
      have_prev_q <= 1'b0;
      last_q      <= '0;
    end else if (cs_rise) begin
      tgl_seen_q <= tgl_s2_q;
      if (frame_ok && (st_q == dwc_pkg::ST_IDLE)) begin
        last_q      <= rx_frm;
        have_prev_q <= 1'b1;
      end
    end
  end

  // store time counted in system cycles
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q        <= dwc_pkg::ST_BOOT;
      store_cnt_q <= 22'h0;
    end else if (ce) begin
      case (st_q)
        dwc_pkg::ST_BOOT: begin
          st_q <= dwc_pkg::ST_IDLE;
        end
        dwc_pkg::ST_IDLE: begin
          store_cnt_q <= 22'h0;
          if (store_go) begin
            st_q <= dwc_pkg::ST_STORE;
          end
        end
        dwc_pkg::ST_STORE: begin
          store_cnt_q <= store_cnt_q + 22'h1;
          if (store_done) begin
            st_q <= dwc_pkg::ST_IDLE;
          end
        end
        default: begin
          st_q <= dwc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // short low pulse after a store and after reloads and reads
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdy_cnt_q <= 4'h0;
    end else if (ce) begin
      if (store_done || (rld_rise && rld_armed_q) ||
          (exec_go && ((cur.cmd == dwc_pkg::CMD_RELOAD_ALL) ||
                       (cur.cmd == dwc_pkg::CMD_READ_NV) ||
                       (cur.cmd == dwc_pkg::CMD_READ_WIP)))) begin
        rdy_cnt_q <= `DWC_RDY_PULSE;
      end else if (rdy_cnt_q != 4'h0) begin
        rdy_cnt_q <= rdy_cnt_q - 4'h1;
      end
    end
  end

  assign rdy_o  = 1'b0;
  // held low through the whole store
  assign rdy_oe = (st_q != dwc_pkg::ST_IDLE) || (rdy_cnt_q != 4'h0);

  // a complete strobe pulse is needed
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rld_armed_q <= 1'b0;
    end else if (rld_fall) begin
      rld_armed_q <= 1'b1;
    end else if (rld_rise) begin
      rld_armed_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int ch = 0; ch < 2; ch++) begin
        wiper_setting_register[ch] <= `DWC_WIPER_MID;
      end
    end else if (ce) begin
      for (int ch = 0; ch < 2; ch++) begin
        if (st_q == dwc_pkg::ST_BOOT) begin
          wiper_setting_register[ch] <= nonvolatile_store[ch][9:0];
        end else if (rld_fall) begin
          wiper_setting_register[ch] <= `DWC_WIPER_MID;
        end else if (rld_rise && rld_armed_q) begin
          wiper_setting_register[ch] <= nonvolatile_store[ch][9:0];
        end else if (exec_go) begin
          case (cur.cmd)
            dwc_pkg::CMD_RESTORE: begin
              if (cur.addr[0] == 1'(ch)) begin
                wiper_setting_register[ch] <= nonvolatile_store[ch][9:0];
              end
            end
            dwc_pkg::CMD_RELOAD_ALL: begin
              wiper_setting_register[ch] <= nonvolatile_store[ch][9:0];
            end
            dwc_pkg::CMD_WRITE_WIP: begin
              if (wp_ok && (cur.addr[0] == 1'(ch))) begin
                wiper_setting_register[ch] <= cur.data[9:0];
              end
            end
            default: begin
              if (wp_ok && dwc_hits(cur, 1'(ch))) begin
                wiper_setting_register[ch] <=
                  dwc_adjust(wiper_setting_register[ch], cur.cmd);
              end
            end
          endcase
        end
      end
    end
  end

  assign wiper_setting_channel_one = wiper_setting_register[0];
  assign wiper_setting_channel_two = wiper_setting_register[1];

  // midscale wipers; user words at 2..14
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int a = 0; a < `DWC_NV_WORDS; a++) begin
        nonvolatile_store[a] <= 16'h0;
      end
      nonvolatile_store[0]  <= {6'h0, `DWC_WIPER_MID};
      nonvolatile_store[1]  <= {6'h0, `DWC_WIPER_MID};
      nonvolatile_store[15] <= `DWC_FACTORY_WORD;
    end else if (ce && store_go) begin
      // code 2 stores wiper, code 3 stores word
      if (cur.cmd == dwc_pkg::CMD_STORE_WIP) begin
        nonvolatile_store[{3'h0, cur.addr[0]}] <=
          {6'h0, wiper_setting_register[cur.addr[0]]};
      end else if (cur.addr < `DWC_ADDR_USER_FIRST) begin
        nonvolatile_store[cur.addr] <= {6'h0, cur.data[9:0]};
      end else begin
        nonvolatile_store[cur.addr] <= cur.data;
      end
    end
  end

  // echo last frame; readback replaces it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reply_q <= 24'h0;
    end else if (exec_go && (cur.cmd == dwc_pkg::CMD_READ_NV)) begin
      reply_q <= {cur.cmd, cur.addr, nonvolatile_store[cur.addr]};
    end else if (exec_go && (cur.cmd == dwc_pkg::CMD_READ_WIP)) begin
      reply_q <= {cur.cmd, cur.addr, 6'h0, wiper_setting_register[cur.addr[0]]};
    end else if (cs_rise && frame_ok && (st_q == dwc_pkg::ST_IDLE)) begin
      reply_q <= rx_sh_q;
    end
  end

  // ---------------- checks ----------------
  a_store_lock: assert property (@(posedge clk) disable iff (!rst_b)
    (st_q == dwc_pkg::ST_STORE && cs_rise && !rld_fall && !rld_rise) |=>
    $stable(wiper_setting_channel_one) && $stable(wiper_setting_channel_two) &&
    $stable(reply_q))
    else $error("frame taken during store");
  a_store_rdy_low: assert property (@(posedge clk) disable iff (!rst_b)
    (st_q == dwc_pkg::ST_STORE) |-> rdy_oe)
    else $error("ready released during store");
  a_store_done_rdy: assert property (@(posedge clk) disable iff (!rst_b)
    (store_done && ce) |=> rdy_oe ##4 !rdy_oe)
    else $error("ready pulse after store wrong");
  a_wp_blocks_write: assert property (@(posedge clk) disable iff (!rst_b)
    (exec_go && !wp_ok && !rld_fall && !rld_rise &&
     cur.cmd == dwc_pkg::CMD_WRITE_WIP)
    |=> $stable(wiper_setting_channel_one) && $stable(wiper_setting_channel_two))
    else $error("write protect ignored");
  a_strobe_mid: assert property (@(posedge clk) disable iff (!rst_b)
    (rld_fall && st_q != dwc_pkg::ST_BOOT) |=>
    (wiper_setting_channel_one == `DWC_WIPER_MID) &&
    (wiper_setting_channel_two == `DWC_WIPER_MID))
    else $error("strobe did not force midscale");
  a_strobe_reload: assert property (@(posedge clk) disable iff (!rst_b)
    (rld_rise && rld_armed_q && st_q != dwc_pkg::ST_BOOT) |=>
    (wiper_setting_channel_one == $past(nonvolatile_store[0][9:0])) &&
    (wiper_setting_channel_two == $past(nonvolatile_store[1][9:0])))
    else $error("strobe rise did not reload");
  a_write_ch_two: assert property (@(posedge clk) disable iff (!rst_b)
    (exec_go && wp_ok && !rld_fall && !rld_rise && cur.addr[0] &&
     cur.cmd == dwc_pkg::CMD_WRITE_WIP) |=>
    wiper_setting_channel_two == $past(cur.data[9:0]))
    else $error("direct write missed");
  a_inc_saturate: assert property (@(posedge clk) disable iff (!rst_b)
    (exec_go && wp_ok && !rld_fall && !rld_rise &&
     cur.cmd == dwc_pkg::CMD_INC1_ALL &&
     wiper_setting_channel_one == `DWC_WIPER_MAX) |=>
    wiper_setting_channel_one == `DWC_WIPER_MAX)
    else $error("increment wrapped");
  a_boot_load: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && st_q == dwc_pkg::ST_BOOT) |=>
    wiper_setting_channel_one == $past(nonvolatile_store[0][9:0]))
    else $error("boot load missed");
  a_sdo_off: assert property (@(posedge clk) disable iff (!rst_b)
    cs_n |-> !sdo_oe)
    else $error("serial output driven with chip select high");

  c_store: cover property (@(posedge clk) disable iff (!rst_b) store_done);
  c_write: cover property (@(posedge clk) disable iff (!rst_b)
    exec_go && cur.cmd == dwc_pkg::CMD_WRITE_WIP);
  c_strobe: cover property (@(posedge clk) disable iff (!rst_b)
    rld_rise && rld_armed_q);
endmodule : dwc_dual_wiper_ctrl

// ===== tb/dwc_dual_wiper_ctrl_bench.sv
// self-checking bench for the dual wiper command controller
// assumes the serial host model and a shortened store time
`timescale 1ns/1ps
module dwc_dual_wiper_ctrl_bench;
  localparam int unsigned STORE_N = 400;

  logic       clk;
  logic       rst_b;
  logic       wp_n;
  logic       strobe_n;
  logic       sclk;
  logic       cs_n;
  logic       sdi;
  logic       sdo_o;
  logic       sdo_oe;
  logic       rdy_o;
  logic       rdy_oe;
  logic [9:0] wip1;
  logic [9:0] wip2;
  logic       sdo_line;
  logic [23:0] prev;
  logic [43:0] ops [18];
  logic [47:0] rx;
  int          fail_count;
  int          tests_run;
  int          n;

  // open-drain output with pull-up
  assign sdo_line = ~sdo_oe;

  dwc_dual_wiper_ctrl #(.STORE_CYCLES(STORE_N)) i_dut (
    .clk                       (clk),
    .rst_b                     (rst_b),
    .ce                        (1'b1),
    .sclk                      (sclk),
    .cs_n                      (cs_n),
    .sdi                       (sdi),
    .sdo_o                     (sdo_o),
    .sdo_oe                    (sdo_oe),
    .wp_n                      (wp_n),
    .hardware_reload_strobe_n  (strobe_n),
    .rdy_o                     (rdy_o),
    .rdy_oe                    (rdy_oe),
    .wiper_setting_channel_one (wip1),
    .wiper_setting_channel_two (wip2)
  );

  dwc_spi_host i_host (
    .sclk     (sclk),
    .cs_n     (cs_n),
    .sdi      (sdi),
    .sdo_line (sdo_line)
  );

  initial clk = 1'b0;
  always #5 clk = ~clk;

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out;
    if (fail_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out

  task automatic gap(input int cycles);
    repeat (cycles) @(posedge clk);
    #1;
  endtask : gap

  // sends one frame, compares the echo, then lets the command settle
  task automatic frame(input logic [23:0] w, input logic taken);
    logic [47:0] r;
    i_host.xfer({24'h000000, w}, 24, r);
    check(r[23:0], prev);
    gap(8);
    check({23'h000000, sdo_oe}, 24'h000000);
    check({22'h000000, sdo_o, rdy_o}, 24'h000000);
    if (taken) begin
      prev = w;
    end
  endtask : frame

  task automatic wait_ready(output int cnt);
    cnt = 0;
    while (rdy_oe !== 1'b0 && cnt < 600) begin
      gap(1);
      cnt++;
    end
  endtask : wait_ready

  initial begin
    #200000;
    fail_count++;
    close_out();
  end

  initial begin
    // step table: frame word, expected wiper one, expected wiper two
    ops = '{{24'h400000, 10'h080, 10'h200}, {24'he00000, 10'h081, 10'h200},
            {24'h600000, 10'h080, 10'h200}, {24'hc00000, 10'h100, 10'h200},
            {24'hb003ff, 10'h3ff, 10'h200}, {24'he00000, 10'h3ff, 10'h200},
            {24'hc00000, 10'h3ff, 10'h200}, {24'hb00000, 10'h000, 10'h200},
            {24'h600000, 10'h000, 10'h200}, {24'h400000, 10'h000, 10'h200},
            {24'hf00000, 10'h001, 10'h201}, {24'h700000, 10'h000, 10'h200},
            {24'h500000, 10'h000, 10'h100}, {24'hd00000, 10'h000, 10'h200},
            {24'he10000, 10'h000, 10'h201}, {24'h100000, 10'h100, 10'h201},
            {24'hb103ff, 10'h100, 10'h3ff}, {24'h800000, 10'h100, 10'h200}};
    fail_count = 0;
    tests_run  = 0;
    prev       = 24'h000000;
    rst_b      = 1'b0;
    wp_n       = 1'b1;
    strobe_n   = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    rst_b = 1'b1;
    gap(3);
    check({14'h0, wip1}, 24'h000200);
    check({14'h0, wip2}, 24'h000200);
    frame(24'hb00100, 1'b1);
    check({14'h0, wip1}, 24'h000100);
    frame(24'h200000, 1'b1);
    check({23'h0, rdy_oe}, 24'h000001);
    frame(24'hb003ff, 1'b0);
    check({14'h0, wip1}, 24'h000100);
    check({23'h0, rdy_oe}, 24'h000001);
    wait_ready(n);
    check({23'h0, n > 200 && n < 400}, 24'h000001);
    frame(24'hb10200, 1'b1);
    frame(24'h210000, 1'b1);
    wait_ready(n);
    frame(24'h910000, 1'b1);
    prev = 24'h910200;
    frame(24'ha00000, 1'b1);
    prev = 24'ha00100;
    frame(24'h000000, 1'b1);
    foreach (ops[i]) begin
      frame(ops[i][43:20], 1'b1);
      check({14'h0, wip1}, {14'h0, ops[i][19:10]});
      check({14'h0, wip2}, {14'h0, ops[i][9:0]});
    end
    wait_ready(n);
    wp_n = 1'b0;
    gap(4);
    frame(24'hb00300, 1'b1);
    check({14'h0, wip1}, 24'h000100);
    frame(24'h32abcd, 1'b1);
    frame(24'he10000, 1'b1);
    check({14'h0, wip2}, 24'h000200);
    // no-operation frame before protection is lifted
    frame(24'h000000, 1'b1);
    wp_n = 1'b1;
    gap(4);
    frame(24'h920000, 1'b1);
    prev = 24'h920000;
    frame(24'h32abcd, 1'b1);
    wait_ready(n);
    frame(24'h920000, 1'b1);
    prev = 24'h92abcd;
    frame(24'h000000, 1'b1);
    frame(24'h3f1234, 1'b1);
    frame(24'h9f0000, 1'b1);
    prev = 24'h9f0000;
    frame(24'hb003ff, 1'b1);
    strobe_n = 1'b0;
    gap(5);
    check({14'h0, wip1}, 24'h000200);
    gap(20);
    check({14'h0, wip1}, 24'h000200);
    strobe_n = 1'b1;
    gap(5);
    check({14'h0, wip1}, 24'h000100);
    check({14'h0, wip2}, 24'h000200);
    wait_ready(n);
    i_host.xfer({25'h0, 23'h3003ff}, 23, rx);
    gap(8);
    check({14'h0, wip1}, 24'h000100);
    i_host.xfer({24'hb003ff, 24'hb00155}, 48, rx);
    gap(8);
    check({14'h0, wip1}, 24'h000155);
    prev = 24'hb00155;
    frame(24'he00000, 1'b1);
    check({14'h0, wip1}, 24'h000156);
    // bare chip-select pulse repeats the last frame
    i_host.xfer(48'h0, 0, rx);
    gap(8);
    check({14'h0, wip1}, 24'h000157);
    close_out();
  end
endmodule : dwc_dual_wiper_ctrl_bench

// ===== tb/dwc_spi_host.sv
// serial host model that drives frames into the wiper controller
// assumes the bench resolves the open-drain output line and calls xfer
`timescale 1ns/1ps
module dwc_spi_host (
  // serial link
  output logic      sclk,
  output logic      cs_n,
  output logic      sdi,
  // returned line
  input  wire logic sdo_line
);
  // link clock stands low and select high between frames
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi  = 1'b0;
  end

  // frame shifted msb first, sampled on rising edge
  task automatic xfer(input logic [47:0] word, input int nbits, output logic [47:0] rx);
    rx   = '0;
    cs_n = 1'b0;
    #20;
    for (int i = nbits - 1; i >= 0; i--) begin
      sdi = word[i];
      #16;
      rx   = {rx[46:0], sdo_line};
      sclk = 1'b1;
      #16;
      sclk = 1'b0;
    end
    #16;
    cs_n = 1'b1;
    // released data line shows the inverse of the last bit
    sdi  = ~sdi;
  endtask : xfer
endmodule : dwc_spi_host
